// *** rtl/spmc_power_ctrl.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "spmc_defs.svh"
// Summary of operation
// - Mode field: 00 full, 01 watch, 10 shutdown, 11 reduced.
// - Mode field resets to 00, full power.
// - PLL bit 0 permits, 1 blocks shutdown; watch only.
// - Sleep only after continuous no-energy; energy restarts timing.
// - Go-sleep value counts in 20 ms units.
// - Go-sleep value resets to 80, 1.6 s.
module spmc_power_ctrl #(
  parameter logic [23:0] UNIT_CYCLES = 24'(`SPMC_UNIT_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic energy_detect,
  output logic pll_power_down,
  output logic clocks_gated,
  output logic soft_shutdown,
  output logic reduced_power,
  output logic traffic_enable
);
  logic energy_s;
  logic pll_keep_reg, pll_keep_next;
  spmc_pkg::spmc_mode_t mode_reg, mode_next;
  logic [7:0] sleepdly_reg, sleepdly_next;
  spmc_pkg::spmc_ed_state_t ed_reg, ed_next;
  logic [23:0] unit_cnt_reg, unit_cnt_next;
  logic [7:0] units_reg, units_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic pll_pd_reg, pll_pd_next;
  logic gated_reg, gated_next;
  logic shut_reg, shut_next;
  logic reduced_reg, reduced_next;
  logic traffic_reg, traffic_next;
  logic access, hit;

  spmc_sync u_energy_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .d(energy_detect),
    .q(energy_s)
  );

  assign access = psel && penable && !pready_reg;
  always_comb begin
    hit = (paddr == `SPMC_ADDR_FACTORY) || (paddr == `SPMC_ADDR_PWRCTL) ||
          (paddr == `SPMC_ADDR_SLEEPDLY) || (paddr == `SPMC_ADDR_STATUS);
  end

  // Register file: one wait state, answer in the second access cycle.
  always_comb begin
    pll_keep_next = pll_keep_reg;
    mode_next = mode_reg;
    sleepdly_next = sleepdly_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (access) begin
      pready_next = 1'b1;
      pslverr_next = !hit;
      prdata_next = 32'h0;
      if (pwrite) begin
        if (paddr == `SPMC_ADDR_PWRCTL) begin
          // A plain write takes effect at once, shutdown included.
          pll_keep_next = pwdata[`SPMC_PLL_KEEP_BIT];
          mode_next = spmc_pkg::spmc_mode_t'(pwdata[`SPMC_MODE_HI:`SPMC_MODE_LO]);
        end else if (paddr == `SPMC_ADDR_SLEEPDLY) begin
          sleepdly_next = pwdata[7:0];
        end
      end else begin
        case (paddr)
          `SPMC_ADDR_FACTORY: prdata_next = {24'h0, `SPMC_FACTORY_RST};
          `SPMC_ADDR_PWRCTL: prdata_next = {26'h0, pll_keep_reg, mode_reg, 3'h0};
          `SPMC_ADDR_SLEEPDLY: prdata_next = {24'h0, sleepdly_reg};
          `SPMC_ADDR_STATUS: prdata_next = {29'h0, energy_s, ed_reg};
          default: prdata_next = 32'h0;
        endcase
      end
    end
  end

  // Energy-watch timer: a unit counter of 20 ms and a unit tally.
  always_comb begin
    ed_next = ed_reg;
    unit_cnt_next = unit_cnt_reg;
    units_next = units_reg;
    if (mode_reg != spmc_pkg::spmc_energy_watch_state) begin
      ed_next = spmc_pkg::spmc_st_awake;
      unit_cnt_next = 24'h0;
      units_next = 8'h0;
    end else begin
      case (ed_reg)
        spmc_pkg::spmc_st_awake: begin
          ed_next = spmc_pkg::spmc_st_watching;
          unit_cnt_next = 24'h0;
          units_next = 8'h0;
        end
        spmc_pkg::spmc_st_watching: begin
          if (energy_s) begin
            unit_cnt_next = 24'h0;
            units_next = 8'h0;
          end else if (units_reg >= sleepdly_reg) begin
            ed_next = spmc_pkg::spmc_st_asleep;
          end else if (unit_cnt_reg == UNIT_CYCLES - 24'h1) begin
            unit_cnt_next = 24'h0;
            units_next = units_reg + 8'h1;
          end else begin
            unit_cnt_next = unit_cnt_reg + 24'h1;
          end
        end
        spmc_pkg::spmc_st_asleep: begin
          if (energy_s) begin
            ed_next = spmc_pkg::spmc_st_watching;
            unit_cnt_next = 24'h0;
            units_next = 8'h0;
          end
        end
        default: ed_next = spmc_pkg::spmc_st_awake;
      endcase
    end
  end

  // Output decode of the mode field and the energy-watch state.
  // The mode term keeps the PLL up in the cycle after software leaves energy watch.
  always_comb begin
    shut_next = (mode_reg == spmc_pkg::spmc_soft_shutdown_state);
    reduced_next = (mode_reg == spmc_pkg::spmc_reduced_power_state);
    gated_next = shut_next || (ed_reg == spmc_pkg::spmc_st_asleep);
    pll_pd_next = (ed_reg == spmc_pkg::spmc_st_asleep) && (mode_reg == spmc_pkg::spmc_energy_watch_state) &&
                  !pll_keep_reg;
    traffic_next = !shut_next && (ed_reg != spmc_pkg::spmc_st_asleep);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_keep_reg <= 1'b0;
      mode_reg <= spmc_pkg::spmc_full_power_state;
      sleepdly_reg <= `SPMC_SLEEPDLY_RST;
      ed_reg <= spmc_pkg::spmc_st_awake;
      unit_cnt_reg <= 24'h0;
      units_reg <= 8'h0;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      pll_pd_reg <= 1'b0;
      gated_reg <= 1'b0;
      shut_reg <= 1'b0;
      reduced_reg <= 1'b0;
      traffic_reg <= 1'b1;
    end else if (clk_en) begin
      pll_keep_reg <= pll_keep_next;
      mode_reg <= mode_next;
      sleepdly_reg <= sleepdly_next;
      ed_reg <= ed_next;
      unit_cnt_reg <= unit_cnt_next;
      units_reg <= units_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      pll_pd_reg <= pll_pd_next;
      gated_reg <= gated_next;
      shut_reg <= shut_next;
      reduced_reg <= reduced_next;
      traffic_reg <= traffic_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pll_power_down = pll_pd_reg;
  assign clocks_gated = gated_reg;
  assign soft_shutdown = shut_reg;
  assign reduced_power = reduced_reg;
  assign traffic_enable = traffic_reg;

  property p_mode_decode;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> (soft_shutdown == $past(mode_reg == spmc_pkg::spmc_soft_shutdown_state)) &&
               (reduced_power == $past(mode_reg == spmc_pkg::spmc_reduced_power_state));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("Mode decode mismatch.");

  property p_reset_mode;
    @(posedge pclk) $rose(presetn) |-> mode_reg == spmc_pkg::spmc_full_power_state;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("Mode not full power after reset.");

  property p_shut_write;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && access && pwrite && paddr == `SPMC_ADDR_PWRCTL && pwdata[4:3] == 2'b10) ##1 clk_en
      |=> soft_shutdown;
  endproperty
  a_shut_write: assert property (p_shut_write) else $error("Shutdown write ignored.");

  property p_pll_only_sleep;
    @(posedge pclk) disable iff (!presetn)
    pll_power_down |-> $past(ed_reg == spmc_pkg::spmc_st_asleep) && !$past(pll_keep_reg);
  endproperty
  a_pll_only_sleep: assert property (p_pll_only_sleep) else $error("PLL down outside sleep.");

  property p_energy_restart;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && energy_s && ed_reg == spmc_pkg::spmc_st_watching) |=> units_reg == 8'h0;
  endproperty
  a_energy_restart: assert property (p_energy_restart) else $error("Energy did not restart timing.");

  property p_unit_bound;
    @(posedge pclk) disable iff (!presetn)
    unit_cnt_reg < UNIT_CYCLES;
  endproperty
  a_unit_bound: assert property (p_unit_bound) else $error("Unit counter overran 20 ms.");

  property p_sleep_enough;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && ed_reg == spmc_pkg::spmc_st_watching && ed_next == spmc_pkg::spmc_st_asleep)
      |-> units_reg >= sleepdly_reg;
  endproperty
  a_sleep_enough: assert property (p_sleep_enough) else $error("Slept too early.");

  property p_dly_reset;
    @(posedge pclk) $rose(presetn) |-> sleepdly_reg == 8'h50;
  endproperty
  a_dly_reset: assert property (p_dly_reset) else $error("Go-sleep reset value wrong.");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && ed_reg == spmc_pkg::spmc_st_asleep && energy_s &&
     mode_reg == spmc_pkg::spmc_energy_watch_state) ##1 clk_en ##1 clk_en |-> traffic_enable && !pll_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("No wake on energy.");

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) $rose(clocks_gated));
  c_wake: cover property (@(posedge pclk) disable iff (!presetn) $fell(clocks_gated));
  c_shut: cover property (@(posedge pclk) disable iff (!presetn) $rose(soft_shutdown));
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule // spmc_power_ctrl

// *** inc/spmc_defs.svh ***
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH
// Register indices as printed; byte address is four times the index.
`define SPMC_IDX_FACTORY 8'h0d
`define SPMC_IDX_PWRCTL 8'h0e
`define SPMC_IDX_SLEEPDLY 8'h0f
`define SPMC_IDX_STATUS 8'h10
`define SPMC_ADDR_FACTORY 12'h034
`define SPMC_ADDR_PWRCTL 12'h038
`define SPMC_ADDR_SLEEPDLY 12'h03c
`define SPMC_ADDR_STATUS 12'h040
// Field positions.
`define SPMC_PLL_KEEP_BIT 5
`define SPMC_MODE_HI 4
`define SPMC_MODE_LO 3
// Reset values.
`define SPMC_FACTORY_RST 8'h00
`define SPMC_PWRCTL_RST 8'h00
`define SPMC_SLEEPDLY_RST 8'h50
// Timing: one go-sleep unit is 20 ms.
`define SPMC_UNIT_MS 20
`define SPMC_CLK_MHZ 250
`define SPMC_UNIT_CYCLES (`SPMC_UNIT_MS * 1000 * `SPMC_CLK_MHZ)
`endif

// *** inc/spmc_pkg.sv ***
package spmc_pkg;
  typedef enum logic [1:0] {
    spmc_full_power_state = 2'b00,
    spmc_energy_watch_state = 2'b01,
    spmc_soft_shutdown_state = 2'b10,
    spmc_reduced_power_state = 2'b11
  } spmc_mode_t;
  typedef enum logic [1:0] {
    spmc_st_awake = 2'b00,
    spmc_st_watching = 2'b01,
    spmc_st_asleep = 2'b10
  } spmc_ed_state_t;
endpackage

// *** rtl/spmc_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; the output changes once stages two and three agree.
module spmc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic [2:0] s_reg;
  logic [2:0] s_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    s_next = s_reg;
    q_next = q_reg;
    if (ce) begin
      s_next = {s_reg[1:0], d};
      if (s_reg[1] == s_reg[2]) begin
        q_next = s_reg[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= 3'h0;
      q_reg <= 1'b0;
    end else begin
      s_reg <= s_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule // spmc_sync

// *** dv/test_switch_power_mode_control.sv ***
`timescale 1ns/1ps
`include "spmc_defs.svh"
module test_switch_power_mode_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic energy_detect = 1'b1;
  logic pll_power_down;
  logic clocks_gated;
  logic soft_shutdown;
  logic reduced_power;
  logic traffic_enable;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  logic [31:0] lfsr = 32'd96432;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  always #2 pclk = ~pclk;

  // A short unit keeps the go-sleep waits to a few dozen cycles.
  spmc_power_ctrl #(.UNIT_CYCLES(24'h000004)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .energy_detect(energy_detect), .pll_power_down(pll_power_down),
    .clocks_gated(clocks_gated), .soft_shutdown(soft_shutdown), .reduced_power(reduced_power),
    .traffic_enable(traffic_enable)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Holds the request until pready is seen at a rising edge, then idles one cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic err);
    exp_q.push_back({err, w, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic outs(input logic [4:0] x);
    check({27'h0, pll_power_down, clocks_gated, soft_shutdown, reduced_power, traffic_enable}, {27'h0, x});
  endtask

  task automatic wait_gate(input logic v);
    for (int i = 0; i < 60 && clocks_gated !== v; i++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, e[9]});
        if (!e[8]) check(prdata, {24'h000000, e[7:0]});
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SPMC_ADDR_FACTORY, 8'h00, 1'b0);
    apb(1'b0, `SPMC_ADDR_PWRCTL, 8'h00, 1'b0);
    apb(1'b0, `SPMC_ADDR_SLEEPDLY, 8'h50, 1'b0);
    outs(5'b00001);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `SPMC_ADDR_PWRCTL, {3'h0, m[1:0], 3'h0}, 1'b0);
      repeat (3) @(posedge pclk);
      outs({1'b0, m == 2, m == 2, m == 3, m != 2});
      apb(1'b0, `SPMC_ADDR_PWRCTL, {3'h0, m[1:0], 3'h0}, 1'b0);
    end
    $display("test mode decode done");
    apb(1'b0, 12'h044, 8'h00, 1'b1);
    apb(1'b1, 12'h044, 8'h5a, 1'b1);
    apb(1'b1, `SPMC_ADDR_FACTORY, 8'hff, 1'b0);
    apb(1'b0, `SPMC_ADDR_FACTORY, 8'h00, 1'b0);
    lfsr = lfsr_next(lfsr);
    apb(1'b1, `SPMC_ADDR_SLEEPDLY, lfsr[7:0], 1'b0);
    apb(1'b0, `SPMC_ADDR_SLEEPDLY, lfsr[7:0], 1'b0);
    $display("test register access done");
    // Three units of four cycles; the energy pulse must restart the tally.
    apb(1'b1, `SPMC_ADDR_SLEEPDLY, 8'h03, 1'b0);
    apb(1'b1, `SPMC_ADDR_PWRCTL, 8'h08, 1'b0);
    energy_detect <= 1'b0;
    repeat (6) @(posedge pclk);
    lfsr = lfsr_next(lfsr);
    energy_detect <= 1'b1;
    repeat (4 + lfsr[1:0]) @(posedge pclk);
    energy_detect <= 1'b0;
    repeat (9) @(posedge pclk);
    outs(5'b00001);
    // Three units need twelve quiet cycles plus the pin synchroniser before any sleep.
    repeat (6) @(posedge pclk);
    outs(5'b00001);
    wait_gate(1'b1);
    outs(5'b11000);
    apb(1'b0, `SPMC_ADDR_STATUS, 8'h02, 1'b0);
    energy_detect <= 1'b1;
    wait_gate(1'b0);
    outs(5'b00001);
    $display("test energy watch done");
    apb(1'b1, `SPMC_ADDR_PWRCTL, 8'h28, 1'b0);
    energy_detect <= 1'b0;
    wait_gate(1'b1);
    outs(5'b01000);
    energy_detect <= 1'b1;
    wait_gate(1'b0);
    outs(5'b00001);
    $display("test pll keep done");
    // With the enable low nothing may count, so a long quiet spell must not put the block to sleep.
    clk_en <= 1'b0;
    energy_detect <= 1'b0;
    repeat (40) @(posedge pclk);
    outs(5'b00001);
    clk_en <= 1'b1;
    wait_gate(1'b1);
    outs(5'b01000);
    $display("test clock enable done");
    presetn <= 1'b0;
    @(posedge pclk);
    outs(5'b00001);
    presetn <= 1'b1;
    energy_detect <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SPMC_ADDR_PWRCTL, 8'h00, 1'b0);
    apb(1'b0, `SPMC_ADDR_SLEEPDLY, 8'h50, 1'b0);
    outs(5'b00001);
    $display("test mid-run reset done");
    give_verdict;
  end
endmodule // test_switch_power_mode_control
